/* File: inc/xmr_pkg.sv */
// Package with constants and types for the extended mode register bank
package xmr_pkg;
  localparam int ADDR_W = 16;
  localparam int BA_W = 3;
  localparam logic [1:0] SEL_ONE = 2'h1;
  localparam logic [1:0] SEL_TWO = 2'h2;
  localparam logic [1:0] SEL_THREE = 2'h3;
  // Field positions in ext_config_one
  localparam int POS_DLL = 0;
  localparam int POS_DRV = 1;
  localparam int POS_RTT_LO = 2;
  localparam int POS_AL = 3;
  localparam int POS_RTT_HI = 6;
  localparam int POS_CAL = 7;
  localparam int POS_NDQS = 10;
  localparam int POS_RDQS = 11;
  localparam int POS_QOFF = 12;
  localparam int POS_RSV1 = 13;
  // Field positions in ext_config_two
  localparam int POS_PARTIAL_REFRESH_SELECT = 0;
  localparam int POS_DCC = 3;
  localparam int POS_SRATE = 7;
  localparam logic [2:0] AL_MAX = 3'h5;
  localparam logic [2:0] CAL_EXIT = 3'h0;
  localparam logic [2:0] CAL_HIGH = 3'h1;
  localparam logic [2:0] CAL_LOW = 3'h2;
  localparam logic [2:0] CAL_ADJ = 3'h4;
  localparam logic [2:0] CAL_DEF = 3'h7;
  localparam logic [15:0] RST_VAL = 16'h0000;
  localparam int DLL_LOCK_CYC = 200;
  typedef enum logic [2:0] {
    XMR_IDLE    = 3'h0,
    XMR_CAL     = 3'h1,
    XMR_CAL_DEF = 3'h2
  } xmr_cal_st_t;
endpackage

/* File: rtl/xmr_cmd_decode.sv */
// Command decoder for mode-set and bank tracking
`timescale 1ns/1ns
module xmr_cmd_decode (
  input  wire logic       cs_n,
  input  wire logic       ras_n,
  input  wire logic       cas_n,
  input  wire logic       we_n,
  output logic            is_mrs,
  output logic            is_act,
  output logic            is_pre,
  output logic            is_read,
  output logic            is_write,
  output logic            is_sre
);
  always_comb begin
    is_mrs   = !cs_n && !ras_n && !cas_n && !we_n;
    is_act   = !cs_n && !ras_n && cas_n && we_n;
    is_pre   = !cs_n && !ras_n && cas_n && !we_n;
    is_read  = !cs_n && ras_n && !cas_n && we_n;
    is_write = !cs_n && ras_n && !cas_n && !we_n;
    is_sre   = !cs_n && !ras_n && !cas_n && we_n;
  end
endmodule // xmr_cmd_decode

/* File: rtl/xmr_bank.sv */
// Extended mode register bank with decoded fields and checks
`timescale 1ns/1ns
module xmr_bank #(
  parameter int NUM_BANKS = 8
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      cke,
  input  wire logic                      cs_n,
  input  wire logic                      ras_n,
  input  wire logic                      cas_n,
  input  wire logic                      we_n,
  input  wire logic [xmr_pkg::BA_W-1:0]  ba,
  input  wire logic [xmr_pkg::ADDR_W-1:0] addr,
  input  wire logic                      precharge_all,
  output logic                           dll_on,
  output logic                           drive_reduced,
  output logic [2:0]                     added_latency,
  output logic [1:0]                     termination_value,
  output logic [2:0]                     driver_calibration,
  output logic                           cal_drive_en,
  output logic                           cal_drive_level,
  output logic                           dqs_n_en,
  output logic                           rdqs_en,
  output logic                           dm_en,
  output logic                           rdqs_oe,
  output logic                           output_quiet,
  output logic [2:0]                     partial_refresh_select,
  output logic                           duty_corrector,
  output logic                           self_refresh_rate,
  output logic [15:0]                    ext_config_three,
  output logic                           dll_locked,
  output logic                           cfg_written,
  output logic                           protocol_error
);
  // Bank tracking and the partial refresh check only know these two sizes
  if (NUM_BANKS != 4 && NUM_BANKS != 8) begin : g_bad_banks
    $error("NUM_BANKS must be 4 or 8");
  end

  typedef struct packed {
    logic [15:0]         one;
    logic [15:0]         two;
    logic [15:0]         three;
    logic [2:0]          written;
    logic [NUM_BANKS-1:0] open;
    logic                in_sr;
    logic [7:0]          lock_cnt;
    logic                rd_act;
    xmr_pkg::xmr_cal_st_t cal_st;
    logic                err;
    logic                dll_run;
    logic                cal_en;
    logic                cal_hi;
    logic                ndqs_en;
    logic                mask_en;
    logic                rdqs_drv;
    logic                locked;
    logic                all_wr;
  } xmr_state_t;

  xmr_state_t s_q;
  xmr_state_t s_d;
  logic       is_mrs;
  logic       is_act;
  logic       is_pre;
  logic       is_read;
  logic       is_write;
  logic       is_sre;

  xmr_cmd_decode i_xmr_cmd_decode (
    .cs_n     (cs_n),
    .ras_n    (ras_n),
    .cas_n    (cas_n),
    .we_n     (we_n),
    .is_mrs   (is_mrs),
    .is_act   (is_act),
    .is_pre   (is_pre),
    .is_read  (is_read),
    .is_write (is_write),
    .is_sre   (is_sre)
  );

  function automatic logic reserved_one(input logic [15:0] v, input logic [2:0] b);
    logic [2:0] al;
    logic [2:0] cal;
    al  = v[xmr_pkg::POS_AL +: 3];
    cal = v[xmr_pkg::POS_CAL +: 3];
    reserved_one = (al > xmr_pkg::AL_MAX) || b[2] || (v[15:13] != 3'h0) ||
                   !(cal inside {xmr_pkg::CAL_EXIT, xmr_pkg::CAL_HIGH, xmr_pkg::CAL_LOW,
                                 xmr_pkg::CAL_ADJ, xmr_pkg::CAL_DEF});
  endfunction

  always_comb begin
    logic cmd;
    logic [2:0] cal;
    cmd = cke && !cs_n;
    cal = addr[xmr_pkg::POS_CAL +: 3];
    s_d = s_q;
    s_d.rd_act = 1'b0;
    if (cmd && is_act) begin
      s_d.open[ba[$clog2(NUM_BANKS)-1:0]] = 1'b1;
    end
    if (cmd && is_pre) begin
      if (precharge_all) s_d.open = '0;
      else s_d.open[ba[$clog2(NUM_BANKS)-1:0]] = 1'b0;
    end
    if (cmd && is_read) s_d.rd_act = 1'b1;
    // Self refresh entry takes CKE low with the refresh command
    if (!cs_n && is_sre && !cke) s_d.in_sr = 1'b1;
    if (s_q.in_sr && cke) begin
      s_d.in_sr = 1'b0;
      s_d.lock_cnt = 8'h00;
    end
    if (s_q.lock_cnt < 8'(xmr_pkg::DLL_LOCK_CYC)) s_d.lock_cnt = s_q.lock_cnt + 8'h01;
    if (cmd && is_mrs && ba[1:0] != 2'h0) begin
      if (s_q.open != '0) s_d.err = 1'b1;
      case (ba[1:0])
        xmr_pkg::SEL_ONE: begin
          s_d.one = addr;
          s_d.written[0] = 1'b1;
          if (reserved_one(addr, ba)) s_d.err = 1'b1;
          if (s_q.cal_st == xmr_pkg::XMR_CAL_DEF && cal != xmr_pkg::CAL_EXIT) s_d.err = 1'b1;
          if (addr[xmr_pkg::POS_DLL] == 1'b0 && s_q.one[xmr_pkg::POS_DLL] == 1'b1) begin
            s_d.lock_cnt = 8'h00;
          end
          case (cal)
            xmr_pkg::CAL_EXIT: s_d.cal_st = xmr_pkg::XMR_IDLE;
            xmr_pkg::CAL_DEF:  s_d.cal_st = xmr_pkg::XMR_CAL_DEF;
            default:           s_d.cal_st = xmr_pkg::XMR_CAL;
          endcase
        end
        xmr_pkg::SEL_TWO: begin
          s_d.two = addr;
          s_d.written[1] = 1'b1;
          if (ba[2] || (addr & 16'hff70) != 16'h0000) s_d.err = 1'b1;
          if (NUM_BANKS == 4 && addr[1:0] == 2'h3) s_d.err = 1'b1;
        end
        default: begin
          s_d.three = addr;
          s_d.written[2] = 1'b1;
          if (ba[2] || addr != 16'h0000) s_d.err = 1'b1;
        end
      endcase
    end else if (cmd && !is_mrs && s_q.cal_st != xmr_pkg::XMR_IDLE &&
                 (is_act || is_read || is_write || is_pre)) begin
      s_d.err = 1'b1;
    end
    // Gated outputs taken from the next state so every pin leaves a flop
    s_d.dll_run  = !s_d.one[xmr_pkg::POS_DLL] && !s_d.in_sr;
    s_d.cal_en   = s_d.one[xmr_pkg::POS_CAL +: 3] inside {xmr_pkg::CAL_HIGH, xmr_pkg::CAL_LOW};
    s_d.cal_hi   = s_d.one[xmr_pkg::POS_CAL +: 3] == xmr_pkg::CAL_HIGH;
    s_d.ndqs_en  = !s_d.one[xmr_pkg::POS_NDQS] && !s_d.one[xmr_pkg::POS_QOFF];
    s_d.mask_en  = !s_d.one[xmr_pkg::POS_RDQS];
    s_d.rdqs_drv = s_d.one[xmr_pkg::POS_RDQS] && s_d.rd_act &&
                   !s_d.one[xmr_pkg::POS_QOFF];
    s_d.locked   = s_d.dll_run && s_d.lock_cnt >= 8'(xmr_pkg::DLL_LOCK_CYC);
    s_d.all_wr   = &s_d.written;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{one: xmr_pkg::RST_VAL, two: xmr_pkg::RST_VAL, three: xmr_pkg::RST_VAL,
               written: 3'h0, open: '0, in_sr: 1'b0, lock_cnt: 8'h00, rd_act: 1'b0,
               cal_st: xmr_pkg::XMR_IDLE, err: 1'b0, dll_run: 1'b1, cal_en: 1'b0,
               cal_hi: 1'b0, ndqs_en: 1'b1, mask_en: 1'b1, rdqs_drv: 1'b0, locked: 1'b0,
               all_wr: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    dll_on             = s_q.dll_run;
    drive_reduced      = s_q.one[xmr_pkg::POS_DRV];
    added_latency      = s_q.one[xmr_pkg::POS_AL +: 3];
    termination_value  = {s_q.one[xmr_pkg::POS_RTT_HI], s_q.one[xmr_pkg::POS_RTT_LO]};
    driver_calibration = s_q.one[xmr_pkg::POS_CAL +: 3];
    cal_drive_en       = s_q.cal_en;
    cal_drive_level    = s_q.cal_hi;
    output_quiet       = s_q.one[xmr_pkg::POS_QOFF];
    dqs_n_en           = s_q.ndqs_en;
    rdqs_en            = s_q.one[xmr_pkg::POS_RDQS];
    dm_en              = s_q.mask_en;
    rdqs_oe            = s_q.rdqs_drv;
    partial_refresh_select = s_q.two[xmr_pkg::POS_PARTIAL_REFRESH_SELECT +: 3];
    duty_corrector     = s_q.two[xmr_pkg::POS_DCC];
    self_refresh_rate  = s_q.two[xmr_pkg::POS_SRATE];
    ext_config_three   = s_q.three;
    dll_locked         = s_q.locked;
    cfg_written        = s_q.all_wr;
    protocol_error     = s_q.err;
  end
endmodule // xmr_bank

/* File: bench/xmr_ctrl_model.sv */
// Controller model driving the command and address pins
`timescale 1ns/1ns
module xmr_ctrl_model (
  input wire logic    sys_clk,
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [15:0] addr,
  output logic        precharge_all
);
  initial {cke, cs_n, ras_n, cas_n, we_n, ba, addr, precharge_all} = {5'h0f, 20'h0};
  // Lines scrambled after use so stale values never look valid
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a,
                     input logic k);
    @(negedge sys_clk);
    {cke, cs_n, ras_n, cas_n, we_n} = {k, c};
    {ba, addr, precharge_all} = {b, a, a[10]};
    @(negedge sys_clk);
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    {ba, addr} = ~{ba, addr};
  endtask
  task automatic mrs(input logic [1:0] b, input logic [12:0] a);
    cmd(4'h0, {1'b0, b}, {3'h0, a}, 1'b1);
  endtask
endmodule // xmr_ctrl_model

/* File: bench/xmr_bank_asserts.sv */
// Port-level assertions for the extended mode register bank
`timescale 1ns/1ns
module xmr_bank_asserts (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [2:0]  ba,
  input wire logic [15:0] addr,
  input wire logic        dll_on,
  input wire logic [2:0]  added_latency,
  input wire logic [1:0]  termination_value,
  input wire logic        rdqs_en,
  input wire logic        dm_en,
  input wire logic        rdqs_oe,
  input wire logic [2:0]  partial_refresh_select,
  input wire logic        output_quiet,
  input wire logic        duty_corrector,
  input wire logic        protocol_error
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic m1, m2, rd, sr;
  assign m1 = cke && !cs_n && !ras_n && !cas_n && !we_n && ba[1:0] == 2'h1;
  assign m2 = cke && !cs_n && !ras_n && !cas_n && !we_n && ba[1:0] == 2'h2;
  assign rd = cke && !cs_n && ras_n && !cas_n && we_n;
  assign sr = !cke && !cs_n && !ras_n && !cas_n && we_n;
  property p_dll; m1 |=> dll_on == !$past(addr[0]); endproperty
  a_dll: assert property (p_dll) else $error("dll enable wrong");
  property p_lat; m1 |=> added_latency == $past(addr[5:3]); endproperty
  a_lat: assert property (p_lat) else $error("latency wrong");
  property p_rtt; m1 |=> termination_value == {$past(addr[6]), $past(addr[2])}; endproperty
  a_rtt: assert property (p_rtt) else $error("termination wrong");
  property p_ref; m2 |=> partial_refresh_select == $past(addr[2:0]); endproperty
  a_ref: assert property (p_ref) else $error("refresh select wrong");
  property p_dm; m1 |=> dm_en == !$past(addr[11]); endproperty
  a_dm: assert property (p_dm) else $error("mask active with strobe");
  property p_rdqs; rdqs_oe |-> $past(rd); endproperty
  a_rdqs: assert property (p_rdqs) else $error("strobe driven off read");
  property p_hold; !m1 |=> $stable(added_latency); endproperty
  a_hold: assert property (p_hold) else $error("latency changed");
  property p_sr; sr |=> !dll_on; endproperty
  a_sr: assert property (p_sr) else $error("dll on in self refresh");
  property p_quiet; output_quiet |-> !rdqs_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("strobe driven while quiet");
  property p_err; protocol_error |=> protocol_error; endproperty
  a_err: assert property (p_err) else $error("error flag cleared");
  property p_dcc; m2 |=> duty_corrector == $past(addr[3]); endproperty
  a_dcc: assert property (p_dcc) else $error("duty corrector wrong");
endmodule // xmr_bank_asserts
bind xmr_bank xmr_bank_asserts i_xmr_bank_asserts (.sys_clk, .rst, .cke, .cs_n, .ras_n,
  .cas_n, .we_n, .ba, .addr, .dll_on, .added_latency, .termination_value, .rdqs_en, .dm_en,
  .rdqs_oe, .partial_refresh_select, .output_quiet, .duty_corrector, .protocol_error);

/* File: bench/dram_ext_mode_registers_test.sv */
// Self-checking bench for the extended mode register bank
`timescale 1ns/1ns
module dram_ext_mode_registers_test;
  localparam logic [3:0] RD = 4'h5, ACT = 4'h3, NOP = 4'h7, REF = 4'h1;
  logic        sys_clk, rst, cke, cs_n, ras_n, cas_n, we_n, pre_all, dll_on, drive_reduced;
  logic        dqs_n_en, rdqs_en, dm_en, rdqs_oe, output_quiet, duty_corrector, protocol_error;
  logic        dll_locked, cfg_written, cal_drive_en, cal_drive_level, self_refresh_rate;
  logic [2:0]  ba, added_latency, driver_calibration, partial_refresh_select;
  logic [1:0]  termination_value;
  logic [15:0] addr, ext_config_three;
  int          failures, check_count, cycles;
  xmr_ctrl_model i_xmr_ctrl_model (.sys_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
    .precharge_all(pre_all));
  xmr_bank #(.NUM_BANKS(8)) i_xmr_bank (.sys_clk, .rst, .cke, .cs_n, .ras_n, .cas_n, .we_n,
    .ba, .addr, .precharge_all(pre_all), .dll_on, .drive_reduced, .added_latency,
    .termination_value, .driver_calibration, .cal_drive_en, .cal_drive_level, .dqs_n_en,
    .rdqs_en, .dm_en, .rdqs_oe, .output_quiet, .partial_refresh_select, .duty_corrector,
    .self_refresh_rate, .ext_config_three, .dll_locked, .cfg_written, .protocol_error);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Bound well above the roughly 340 cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic t_ext_two();
    for (int p = 0; p < 8; p++) begin
      i_xmr_ctrl_model.mrs(2'h2, {5'h0, p[2], 3'h0, p[0], p[2:0]});
      chk(16'(partial_refresh_select), 16'(p[2:0]));
      chk(16'(duty_corrector), 16'(p[0]));
      chk(16'(self_refresh_rate), 16'(p[2]));
    end
    i_xmr_ctrl_model.mrs(2'h3, 13'h0);
    chk(ext_config_three, 16'h0);
    chk(16'(cfg_written), 16'h0);
  endtask
  task automatic t_ext_one();
    for (int i = 0; i < 6; i++) begin
      i_xmr_ctrl_model.mrs(2'h1, {6'h0, i[1], i[2:0], i[0], i[0], i[2] & i[0]});
      chk(16'(added_latency), 16'(i[2:0]));
      chk(16'(termination_value), 16'(i[1:0]));
      chk(16'(drive_reduced), 16'(i[0]));
      chk(16'(dll_on), 16'(!(i[2] & i[0])));
    end
    chk(16'(cfg_written), 16'h1);
  endtask
  task automatic t_cal();
    logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
    foreach (codes[k]) begin
      i_xmr_ctrl_model.mrs(2'h1, {3'h0, codes[k], 7'h0});
      chk(16'(driver_calibration), 16'(codes[k]));
      chk(16'(cal_drive_en), 16'(codes[k] == 3'h1 || codes[k] == 3'h2));
      chk(16'(cal_drive_level), 16'(codes[k] == 3'h1));
      i_xmr_ctrl_model.mrs(2'h1, 13'h0);
      chk(16'(driver_calibration), 16'h0);
    end
  endtask
  task automatic t_strobe();
    chk(16'(dll_locked), 16'h0);
    repeat (210) @(negedge sys_clk);
    chk(16'(dll_locked), 16'h1);
    for (int j = 0; j < 8; j++) begin
      i_xmr_ctrl_model.mrs(2'h1, {j[2:0], 10'h0});
      chk(16'(dqs_n_en), 16'(!j[0] & !j[2]));
      chk(16'(rdqs_en), 16'(j[1]));
      chk(16'(dm_en), 16'(!j[1]));
      chk(16'(output_quiet), 16'(j[2]));
      i_xmr_ctrl_model.cmd(RD, 3'h0, 16'h0, 1'b1);
      chk(16'(rdqs_oe), 16'(j[1] & !j[2]));
    end
    i_xmr_ctrl_model.mrs(2'h1, 13'h0);
  endtask
  task automatic t_sref_err();
    i_xmr_ctrl_model.cmd(REF, 3'h0, 16'h0, 1'b0);
    chk(16'(dll_on), 16'h0);
    i_xmr_ctrl_model.cmd(NOP, 3'h0, 16'h0, 1'b1);
    chk(16'(dll_on), 16'h1);
    chk(16'(dll_locked), 16'h0);
    chk(16'(protocol_error), 16'h0);
    i_xmr_ctrl_model.cmd(ACT, 3'h0, 16'h0, 1'b1);
    i_xmr_ctrl_model.mrs(2'h1, 13'h0);
    chk(16'(protocol_error), 16'h1);
  endtask
  // Mid-run reset, the only way to clear the sticky error flag
  task automatic pulse_reset();
    @(negedge sys_clk);
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
  endtask
  task automatic t_cal_err();
    pulse_reset();
    chk(16'(protocol_error), 16'h0);
    chk(16'(dll_on), 16'h1);
    i_xmr_ctrl_model.mrs(2'h1, {3'h0, 3'h1, 7'h0});
    i_xmr_ctrl_model.cmd(ACT, 3'h0, 16'h0, 1'b1);
    chk(16'(protocol_error), 16'h1);
    pulse_reset();
    i_xmr_ctrl_model.mrs(2'h1, {3'h0, 3'h7, 7'h0});
    chk(16'(protocol_error), 16'h0);
    i_xmr_ctrl_model.mrs(2'h1, {3'h0, 3'h1, 7'h0});
    chk(16'(protocol_error), 16'h1);
    pulse_reset();
    i_xmr_ctrl_model.mrs(2'h1, 13'h30);
    chk(16'(protocol_error), 16'h1);
  endtask
  initial begin
    rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    i_xmr_ctrl_model.cmd(NOP, 3'h0, 16'h0, 1'b1);
    t_ext_two();
    t_ext_one();
    t_cal();
    t_strobe();
    t_sref_err();
    t_cal_err();
    report_and_stop();
  end
endmodule // dram_ext_mode_registers_test
